/* rtl/dacpd_pkg.sv */
// Constants shared by the power-down control block and its command word receiver.
package dacpd_pkg;
  localparam int N_CH           = 8;
  localparam int DATA_W         = 16;
  localparam int BYTES_PER_WORD = 3;
  localparam int BCNT_W         = 2;
  localparam int CMD_MSB        = 7;
  localparam int CMD_LSB        = 4;
  localparam int SEL_MSB        = 3;
  localparam int SEL_LSB        = 0;
  localparam logic [3:0] CMD_WRITE         = 4'h0;
  localparam logic [3:0] CMD_UPDATE        = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPD     = 4'h3;
  localparam logic [3:0] CMD_POWER_DOWN    = 4'h4;
  localparam logic [3:0] SEL_ALL           = 4'hf;
  localparam logic [BCNT_W-1:0] BCNT_LAST  = 2'h2;
  localparam logic [BCNT_W-1:0] BCNT_DONE  = 2'h3;
  localparam int CLK_MHZ        = 50;
  localparam int SHORT_DLY_US   = 5;
  localparam int LONG_5V_DLY_US = 12;
  localparam int LONG_3V_DLY_US = 30;
  localparam int CNT_W          = 11;
  localparam logic [CNT_W-1:0] SHORT_CYC   = CNT_W'(SHORT_DLY_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] LONG_5V_CYC = CNT_W'(LONG_5V_DLY_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] LONG_3V_CYC = CNT_W'(LONG_3V_DLY_US * CLK_MHZ);
  localparam logic [N_CH-1:0] RST_PD       = 8'h00;
  localparam logic [DATA_W-1:0] RST_CODE   = 16'h0000;
endpackage

/* rtl/dacpd_cmd_if.sv */
// Carries one decoded 24-bit command word from the receiver to the executor.
`timescale 1ns/1ps
interface dacpd_cmd_if;
  import dacpd_pkg::*;
  logic              valid;
  logic [3:0]        cmd;
  logic [3:0]        sel;
  logic [DATA_W-1:0] data;
  modport rx (output valid, output cmd, output sel, output data);
  modport ex (input valid, input cmd, input sel, input data);
endinterface

/* rtl/dacpd_word_rx.sv */
// Assembles three received bytes into one command word and issues it once.
`timescale 1ns/1ps
module dacpd_word_rx
  import dacpd_pkg::*;
(
  input  wire logic  i_clk_sys,
  input  wire logic  i_reset,
  input  wire logic  i_start,
  input  wire logic  i_byte_valid,
  input  wire logic [7:0] i_byte,
  dacpd_cmd_if.rx    cmd_o
);
  logic [BCNT_W-1:0] cnt_q;
  logic [7:0]        first_q;
  logic [7:0]        mid_q;
  logic              valid_q;
  logic [3:0]        cmd_q;
  logic [3:0]        sel_q;
  logic [DATA_W-1:0] data_q;

  // Bytes beyond the third are ignored until the next addressed start.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_start) begin
      cnt_q <= '0;
    end else if (i_byte_valid && cnt_q != BCNT_DONE) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      first_q <= 8'h00;
      mid_q   <= 8'h00;
    end else if (i_byte_valid && !i_start) begin
      if (cnt_q == '0) begin
        first_q <= i_byte;
      end
      if (cnt_q == 2'h1) begin
        mid_q <= i_byte;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      valid_q <= 1'b0;
      cmd_q   <= 4'h0;
      sel_q   <= 4'h0;
      data_q  <= RST_CODE;
    end else begin
      valid_q <= i_byte_valid && !i_start && cnt_q == BCNT_LAST;
      if (i_byte_valid && !i_start && cnt_q == BCNT_LAST) begin
        cmd_q  <= first_q[CMD_MSB:CMD_LSB];
        sel_q  <= first_q[SEL_MSB:SEL_LSB];
        data_q <= {mid_q, i_byte};
      end
    end
  end

  assign cmd_o.valid = valid_q;
  assign cmd_o.cmd   = cmd_q;
  assign cmd_o.sel   = sel_q;
  assign cmd_o.data  = data_q;

  third_byte_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    valid_q |-> $past(i_byte_valid) && $past(cnt_q) == BCNT_LAST)
    else $error("Command issued before the third byte.");
  word_layout_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    valid_q |-> cmd_q == first_q[7:4] && sel_q == first_q[3:0] && data_q[15:8] == mid_q)
    else $error("Command word fields misplaced.");
endmodule

/* rtl/dacpd_top.sv */
// Per-channel power-down, wake-up delay and code registers of an eight-channel converter.
// Function
// - The power-down command powers down the selected channel, or all on broadcast.
// - The power-down command ignores its data word and changes no code register.
// - Holding and active codes of a powered-down channel change only when a write or update selects it.
// - Shared bias is off only while all eight channels are powered down.
// - Any command that updates a channel powers that channel up.
// - With fewer than eight channels down before the wake, the delay is 5 us.
// - With all eight down before the wake, the delay is 12 us at 5 V or 30 us at 3 V.
// - The first byte holds command then channel select, the next two the data word.
// - An update copies the holding code to the active code and wakes the channel.
// - A command runs only after all three bytes of its word have arrived.
`timescale 1ns/1ps
module dacpd_top
  import dacpd_pkg::*;
(
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset,
  input  wire logic                     i_start,
  input  wire logic                     i_byte_valid,
  input  wire logic [7:0]               i_byte,
  input  wire logic                     i_supply_low,
  output logic [dacpd_pkg::N_CH-1:0]    o_chan_down,
  output logic [dacpd_pkg::N_CH-1:0]    o_chan_waking,
  output logic                          o_bias_on,
  output logic [dacpd_pkg::N_CH*dacpd_pkg::DATA_W-1:0] o_active_code
);
  import dacpd_pkg::*;

  dacpd_cmd_if cmd_bus ();

  logic [N_CH-1:0]   pd_q;
  logic [N_CH-1:0]   pd_d;
  logic [N_CH-1:0]   busy_q;
  logic              bias_q;
  logic [DATA_W-1:0] hold_q [N_CH];
  logic [DATA_W-1:0] act_q  [N_CH];
  logic [CNT_W-1:0]  dly_q  [N_CH];
  logic              sup_meta_q;
  logic              sup_low_q;
  logic [N_CH-1:0]   wr_mask;
  logic [N_CH-1:0]   upd_mask;
  logic [N_CH-1:0]   pd_mask;
  logic [N_CH-1:0]   wake;
  logic              all_down;
  logic [CNT_W-1:0]  wake_dly;

  function automatic logic [N_CH-1:0] sel_mask(input logic [3:0] sel);
    logic [N_CH-1:0] m;
    m = '0;
    if (sel == SEL_ALL) begin
      m = '1;
    end else if (sel < 4'(N_CH)) begin
      m[sel[2:0]] = 1'b1;
    end
    return m;
  endfunction

  dacpd_word_rx u_rx (
    .i_clk_sys    (i_clk_sys),
    .i_reset      (i_reset),
    .i_start      (i_start),
    .i_byte_valid (i_byte_valid),
    .i_byte       (i_byte),
    .cmd_o        (cmd_bus)
  );

  // The supply level pin is asynchronous, so only the second flop feeds the delay choice.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sup_meta_q <= 1'b0;
      sup_low_q  <= 1'b0;
    end else begin
      sup_meta_q <= i_supply_low;
      sup_low_q  <= sup_meta_q;
    end
  end

  always_comb begin
    wr_mask  = '0;
    upd_mask = '0;
    pd_mask  = '0;
    if (cmd_bus.valid) begin
      case (cmd_bus.cmd)
        CMD_WRITE: begin
          wr_mask = sel_mask(cmd_bus.sel);
        end
        CMD_UPDATE: begin
          upd_mask = sel_mask(cmd_bus.sel);
        end
        CMD_WRITE_UPD_ALL: begin
          wr_mask  = sel_mask(cmd_bus.sel);
          upd_mask = '1;
        end
        CMD_WRITE_UPD: begin
          wr_mask  = sel_mask(cmd_bus.sel);
          upd_mask = sel_mask(cmd_bus.sel);
        end
        CMD_POWER_DOWN: begin
          pd_mask = sel_mask(cmd_bus.sel);
        end
        default: begin
          pd_mask = '0;
        end
      endcase
    end
  end

  assign all_down = &pd_q;
  assign wake     = upd_mask & pd_q;
  assign pd_d     = (pd_q | pd_mask) & ~upd_mask;
  assign wake_dly = !all_down ? SHORT_CYC : (sup_low_q ? LONG_3V_CYC : LONG_5V_CYC);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pd_q   <= RST_PD;
      bias_q <= 1'b1;
    end else begin
      pd_q   <= pd_d;
      bias_q <= ~&pd_d;
    end
  end

  // Power-down leaves the code registers alone; only writes and updates touch them.
  always_ff @(posedge i_clk_sys) begin
    for (int i = 0; i < N_CH; i++) begin
      if (i_reset) begin
        hold_q[i] <= RST_CODE;
        act_q[i]  <= RST_CODE;
      end else begin
        if (wr_mask[i]) begin
          hold_q[i] <= cmd_bus.data;
        end
        if (upd_mask[i]) begin
          act_q[i] <= wr_mask[i] ? cmd_bus.data : hold_q[i];
        end
      end
    end
  end

  // A power-down during the delay cancels it, and the channel simply stays down.
  always_ff @(posedge i_clk_sys) begin
    for (int i = 0; i < N_CH; i++) begin
      if (i_reset || pd_mask[i]) begin
        dly_q[i]  <= '0;
        busy_q[i] <= 1'b0;
      end else if (wake[i]) begin
        dly_q[i]  <= wake_dly;
        busy_q[i] <= 1'b1;
      end else if (dly_q[i] != '0) begin
        dly_q[i]  <= dly_q[i] - CNT_W'(1);
        busy_q[i] <= dly_q[i] != CNT_W'(1);
      end
    end
  end

  assign o_chan_down   = pd_q;
  assign o_chan_waking = busy_q;
  assign o_bias_on     = bias_q;
  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      o_active_code[i*DATA_W +: DATA_W] = act_q[i];
    end
  end

  pd_enters_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    |pd_mask |=> (pd_q & $past(pd_mask)) == $past(pd_mask))
    else $error("Selected channel not powered down.");
  pd_no_data_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    |pd_mask |=> $stable(hold_q[0]) && $stable(act_q[0]) && $stable(hold_q[7]))
    else $error("Power-down command altered a code register.");
  down_keeps_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    pd_q[0] && !upd_mask[0] && !wr_mask[0] |=> $stable(act_q[0]) && $stable(hold_q[0]))
    else $error("Code of a powered-down channel changed.");
  bias_state_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_bias_on == !(&pd_q))
    else $error("Bias state disagrees with channel flags.");
  update_wakes_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    |upd_mask |=> (pd_q & $past(upd_mask)) == '0)
    else $error("Updated channel still powered down.");
  short_delay_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wake[0] && !all_down |=> dly_q[0] == 11'd250 ##1 (busy_q[0] || pd_q[0])[*8])
    else $error("Short power-up delay wrong.");
  long_delay_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wake[0] && all_down |=> dly_q[0] == ($past(sup_low_q) ? 11'd1500 : 11'd600) && !o_bias_on == 1'b0)
    else $error("Long power-up delay wrong.");
  update_copy_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    upd_mask[0] && !wr_mask[0] |=> act_q[0] == $past(hold_q[0]) && !pd_q[0])
    else $error("Update did not copy holding code.");
  // Nothing is decoded between commands or for unknown codes; unused selects reach no write or power-down.
  idle_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !cmd_bus.valid |-> (wr_mask | upd_mask | pd_mask) == '0)
    else $error("Command decoded without a complete word.");
  no_op_cmd_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    cmd_bus.valid && cmd_bus.cmd > CMD_POWER_DOWN |-> (wr_mask | upd_mask | pd_mask) == '0)
    else $error("Unknown command code acted on a channel.");
  sel_none_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    cmd_bus.valid && cmd_bus.sel[3] && cmd_bus.sel != SEL_ALL |-> (wr_mask | pd_mask) == '0)
    else $error("Unused select reached a channel.");
  write_no_wake_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    cmd_bus.valid && cmd_bus.cmd == CMD_WRITE |=> pd_q == $past(pd_q))
    else $error("Plain write changed a power state.");
  code_kept_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    pd_q[7] && !upd_mask[7] && !wr_mask[7] |=> $stable(act_q[7]) && $stable(hold_q[7]))
    else $error("Code of powered-down channel seven changed.");
  // Wake timer checks.
  wake_starts_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    |wake |=> (busy_q & $past(wake)) == $past(wake))
    else $error("Woken channel shows no power-up delay.");
  bias_restart_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    all_down && |wake |=> o_bias_on)
    else $error("Bias not restarted by the waking update.");
  busy_count_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    busy_q[0] == (dly_q[0] != '0))
    else $error("Waking flag disagrees with its delay counter.");
  delay_ends_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    dly_q[0] == CNT_W'(1) && !pd_mask[0] && !wake[0] |=> !busy_q[0] && dly_q[0] == '0)
    else $error("Power-up delay did not end on time.");
  pd_cancels_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    pd_mask[0] |=> pd_q[0] && !busy_q[0])
    else $error("Power-down left a delay running.");
endmodule

/* sim/dacpd_bus_model.sv */
// Serial front end stand-in that delivers addressed write transactions byte by byte.
`timescale 1ns/1ps
module dacpd_bus_model (
  input  wire logic       i_clk_sys,
  output logic            o_start,
  output logic            o_byte_valid,
  output logic [7:0]      o_byte
);
  initial begin
    o_start      = 1'b0;
    o_byte_valid = 1'b0;
    o_byte       = 8'h00;
  end

  // Sends nb bytes; a fourth byte stands for a master that keeps writing.
  task automatic send_word(input logic [3:0] c, s, input logic [15:0] d, input int nb);
    logic [7:0] b [4];
    b[0] = {c, s};
    b[1] = d[15:8];
    b[2] = d[7:0];
    b[3] = 8'h4f;
    @(posedge i_clk_sys);
    o_start <= 1'b1;
    @(posedge i_clk_sys);
    o_start <= 1'b0;
    for (int k = 0; k < nb; k++) begin
      o_byte_valid <= 1'b1;
      o_byte       <= b[k];
      @(posedge i_clk_sys);
    end
    o_byte_valid <= 1'b0;
    o_byte       <= ~b[nb-1];
  endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the power-down control block.
`timescale 1ns/1ps
module testbench;
  import dacpd_pkg::*;
  logic                   clk, rst, sup_low, st, bv, bias;
  logic [7:0]             by;
  logic [N_CH-1:0]        down, wake, pd, wk;
  logic [N_CH*DATA_W-1:0] code;
  logic [DATA_W-1:0]      hold [N_CH];
  logic [DATA_W-1:0]      act [N_CH];
  int                     mismatches, n_tests;

  dacpd_top u_dacpd_top (.i_clk_sys(clk), .i_reset(rst), .i_start(st), .i_byte_valid(bv),
    .i_byte(by), .i_supply_low(sup_low), .o_chan_down(down), .o_chan_waking(wake),
    .o_bias_on(bias), .o_active_code(code));
  dacpd_bus_model u_dacpd_bus_model (.i_clk_sys(clk), .o_start(st), .o_byte_valid(bv),
    .o_byte(by));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string nm, input logic [127:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] msk(input logic [3:0] s);
    return (s == SEL_ALL) ? 8'hff : ((s < 4'h8) ? (8'h01 << s) : 8'h00);
  endfunction

  task automatic cmp;
    logic [127:0] ex;
    for (int i = 0; i < N_CH; i++) ex[16*i +: 16] = act[i];
    check("chan_down", 128'(down), 128'(pd));
    check("bias_on", 128'(bias), 128'(~&pd));
    check("active_code", code, ex);
  endtask

  task automatic run(input logic [3:0] c, s, input logic [15:0] d, input int nb);
    logic [7:0] m, upd;
    m   = msk(s);
    upd = 8'h00;
    u_dacpd_bus_model.send_word(c, s, d, nb);
    repeat (3) @(posedge clk);
    #1;
    if (c == CMD_WRITE || c == CMD_WRITE_UPD_ALL || c == CMD_WRITE_UPD) begin
      for (int i = 0; i < N_CH; i++) if (m[i]) hold[i] = d;
    end
    if (c == CMD_UPDATE || c == CMD_WRITE_UPD) upd = m;
    if (c == CMD_WRITE_UPD_ALL) upd = 8'hff;
    wk = upd & pd;
    for (int i = 0; i < N_CH; i++) if (upd[i]) act[i] = hold[i];
    if (c == CMD_POWER_DOWN) pd = pd | m;
    pd = pd & ~upd;
    cmp();
  endtask

  task automatic wake_len(input int ch, input int exp);
    int n;
    n = 0;
    check("chan_waking", 128'(wake), 128'(wk));
    while (wake[ch] === 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    // Counting starts two edges after the delay loads, or three after a fourth byte.
    check("wake_len", 128'(n >= exp - 3 && n <= exp - 2), 128'h1);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(20 * 100000);
    mismatches++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    sup_low = 1'b0;
    pd = 8'h00;
    wk = 8'h00;
    for (int i = 0; i < N_CH; i++) hold[i] = RST_CODE;
    for (int i = 0; i < N_CH; i++) act[i] = RST_CODE;
    void'($urandom(88645));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp();
    $display("test reset done");
    for (int i = 0; i < N_CH; i++) run(CMD_WRITE_UPD, 4'(i), 16'($urandom), 3);
    run(CMD_POWER_DOWN, 4'h2, 16'($urandom), 3);
    run(CMD_UPDATE, 4'h2, 16'($urandom), 4);
    wake_len(2, int'(SHORT_CYC));
    $display("test single wake done");
    run(CMD_POWER_DOWN, SEL_ALL, 16'($urandom), 3);
    run(CMD_WRITE, 4'h5, 16'($urandom), 3);
    run(CMD_UPDATE, 4'h5, 16'h0000, 3);
    wake_len(5, int'(LONG_5V_CYC));
    run(CMD_UPDATE, 4'h0, 16'h0000, 3);
    wake_len(0, int'(SHORT_CYC));
    sup_low <= 1'b1;
    run(CMD_POWER_DOWN, SEL_ALL, 16'($urandom), 3);
    run(CMD_WRITE_UPD_ALL, 4'h3, 16'($urandom), 3);
    wake_len(0, int'(LONG_3V_CYC));
    $display("test long wake done");
    for (int j = 0; j < 60; j++) begin
      run(4'($urandom % 8), 4'($urandom), 16'($urandom), 3 + int'($urandom % 2));
    end
    $display("test random done");
    test_done();
  end
endmodule
